// *** src/sosd_pkg.sv ***
// Purpose: Types shared by the shared output stage.
// Assumes: Constants live in sosd_regs.svh.
// Notes: None.
package sosd_pkg;
  typedef logic [47:0] sosd_pixel_t;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_PULSE} sosd_hs_state_t;
endpackage : sosd_pkg

// *** src/sosd_regs.svh ***
// Purpose: Register map, field positions, reset values and timing counts of the shared output stage.
// Assumes: 32-bit AHB-Lite register window, byte addresses, one register per aligned word.
// Notes: Included by bare name; definitions only.
`ifndef SOSD_REGS_SVH
`define SOSD_REGS_SVH

// Register byte offsets
`define SOSD_CTRL_ADDR 8'h00
`define SOSD_HSPOS_ADDR 8'h04
`define SOSD_STATUS_ADDR 8'h08
`define SOSD_SCANLO_ADDR 8'h0C
`define SOSD_SCANHI_ADDR 8'h10

// Control register fields
`define SOSD_CTRL_HS_POL 0
`define SOSD_CTRL_VS_POL 1
`define SOSD_CTRL_VS_SEP 2
`define SOSD_CTRL_DIGITAL 3
`define SOSD_CTRL_PDOWN 4
`define SOSD_CTRL_SCAN_DRV 5
`define SOSD_CTRL_W 6
`define SOSD_CTRL_RST 6'h00

// Sync placement register: position low half, width high half
`define SOSD_HSPOS_POS_LSB 0
`define SOSD_HSPOS_WID_LSB 16
`define SOSD_HSPOS_RST 32'h0008_0004

// Status register fields
`define SOSD_STAT_ACTIVE 0
`define SOSD_STAT_ANA_DET 1
`define SOSD_STAT_DIG_DET 2
`define SOSD_STAT_FULL 3
`define SOSD_STAT_EMPTY 4

// Pixel word lanes (lsb of each 8-bit port)
`define SOSD_BLUE_B_LSB 0
`define SOSD_GREEN_B_LSB 8
`define SOSD_RED_B_LSB 16
`define SOSD_BLUE_A_LSB 24
`define SOSD_GREEN_A_LSB 32
`define SOSD_RED_A_LSB 40

// Timing
`define SOSD_CLK_MHZ 10
`define SOSD_ACT_TIMEOUT_US 100
`define SOSD_ACT_TIMEOUT_CYC (`SOSD_ACT_TIMEOUT_US * `SOSD_CLK_MHZ)
`define SOSD_PIX_DIV 2
`define SOSD_SCAN_BITS 48
`define SOSD_FIFO_DEPTH 8

`endif

// *** src/sosd_top.sv ***
// Purpose: Sync outputs, pixel output stage, activity detect and serial scan register.
// Assumes: Single clock hclk at 10 MHz; the sync, display enable and scan pins are synchronised before use, bus and pixel inputs are not.
// Notes: Registers over AHB-Lite, zero wait states, OKAY always.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "sosd_regs.svh"

// Two-flop synchroniser for pins
module sosd_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      dout <= '0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule : sosd_sync2

// Pixel buffer with valid/ready on both sides
module sosd_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("sosd_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic not_full_reg;
  logic empty_reg;
  wire push = in_valid & not_full_reg;
  wire pop = out_ready & ~empty_reg;

  // Occupancy bookkeeping
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = not_full_reg; // Straight from a flop
  assign out_valid = ~empty_reg;
  assign out_data = mem[rd_ptr_reg];

  // Pointers and flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      not_full_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      not_full_reg <= (count_next != (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end

  // Storage
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule : sosd_fifo

// Contract
// - Horizontal sync out is rebuilt in phase with the incoming sync and its polarity is a control bit.
// - In analog mode the sync position and width are programmable, in digital mode they follow the transmitter.
// - Vertical sync out is the separated or the direct vertical sync, polarity selectable, timing untouched.
// - Horizontal sync out changes only with the pixel data, aligned to the falling edge of the output clock.
// - Six 8-bit pixel ports, red, green, blue, each with even port A and odd port B, bit 7 the msb.
// - Pixel ports and the output clock pair are driven from whichever interface is active.
// - Activity detect is analog sync detected OR digital display enable detected.
// - Activity detect is low when neither interface is active or the chip is powered down.
// - Pixel data outputs are released to high impedance while activity detect is low and the scan drive bit is clear.
// - The tester shifts bits into the 48-bit scan register on the scan input, one per scan clock.
// - The scan register contents can be driven in parallel on all 48 pixel outputs.
// - The scan register is read serially on the scan output in first-in first-out order.
// - One scan clock advances loading and emitting together.
module sosd_top #(
  parameter int PIX_DIV = `SOSD_PIX_DIV,
  parameter int ACT_TIMEOUT_CYC = `SOSD_ACT_TIMEOUT_CYC,
  parameter int FIFO_DEPTH = `SOSD_FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire sosd_pkg::sosd_pixel_t pixel_in_data,
  input wire logic pixel_in_valid,
  output logic pixel_in_ready,
  input wire logic analog_hsync_in,
  input wire logic vsync_in,
  input wire logic composite_vsync_in,
  input wire logic digital_hsync_in,
  input wire logic display_enable_input,
  input wire logic test_shift_clock,
  input wire logic test_shift_in,
  output logic horizontal_sync_output,
  output logic vertical_sync_output,
  output logic [7:0] pixel_out_red_a,
  output logic [7:0] pixel_out_green_a,
  output logic [7:0] pixel_out_blue_a,
  output logic [7:0] pixel_out_red_b,
  output logic [7:0] pixel_out_green_b,
  output logic [7:0] pixel_out_blue_b,
  output logic pixel_out_oe_n,
  output logic pixel_output_clock,
  output logic pixel_output_clock_n,
  output logic activity_detect,
  output logic test_shift_out
);
  import sosd_pkg::*;

  initial begin
    if (PIX_DIV < 1 || PIX_DIV > 256) $error("sosd_top: PIX_DIV out of range");
    if (ACT_TIMEOUT_CYC < 1 || ACT_TIMEOUT_CYC > 65535) $error("sosd_top: ACT_TIMEOUT_CYC out of range");
  end

  localparam int NB = `SOSD_SCAN_BITS;

  // Synchronised pins
  logic [6:0] pin_sync;
  logic [6:0] pin_prev_reg;
  sosd_sync2 #(.WIDTH(7)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din({test_shift_in, test_shift_clock, display_enable_input, digital_hsync_in,
          composite_vsync_in, vsync_in, analog_hsync_in}),
    .dout(pin_sync)
  );
  wire ahs_s = pin_sync[0];
  wire vs_s = pin_sync[1];
  wire cvs_s = pin_sync[2];
  wire dhs_s = pin_sync[3];
  wire de_s = pin_sync[4];
  wire sclk_s = pin_sync[5];
  wire sin_s = pin_sync[6];
  wire ahs_rise = ahs_s & ~pin_prev_reg[0];
  wire de_rise = de_s & ~pin_prev_reg[4];
  wire sclk_rise = sclk_s & ~pin_prev_reg[5];

  // Software registers
  logic [`SOSD_CTRL_W-1:0] ctrl_reg;
  logic [15:0] hs_pos_reg;
  logic [15:0] hs_wid_reg;
  logic ap_valid_reg;
  logic ap_write_reg;
  logic [7:0] ap_addr_reg;
  wire hs_pol = ctrl_reg[`SOSD_CTRL_HS_POL];
  wire vs_pol = ctrl_reg[`SOSD_CTRL_VS_POL];
  wire vs_sep = ctrl_reg[`SOSD_CTRL_VS_SEP];
  wire dig_mode = ctrl_reg[`SOSD_CTRL_DIGITAL];
  wire pdown = ctrl_reg[`SOSD_CTRL_PDOWN];
  wire scan_drv = ctrl_reg[`SOSD_CTRL_SCAN_DRV];

  // Block state
  logic [NB-1:0] scan_reg;
  logic [15:0] ana_timer_reg;
  logic [15:0] dig_timer_reg;
  logic [7:0] div_cnt_reg;
  logic pclk_reg;
  logic pclk_n_reg;
  logic [NB-1:0] pix_reg;
  logic oe_n_reg;
  logic act_reg;
  logic hs_out_reg;
  logic vs_out_reg;
  logic sout_reg;
  sosd_hs_state_t hs_state_reg;
  logic [15:0] hs_cnt_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;

  // Pixel clock divider and falling-edge event, ahead of the buffer that pops on it
  wire div_tick = (div_cnt_reg == 8'(PIX_DIV - 1));
  wire pix_fall = div_tick & pclk_reg;

  // Pixel buffer
  sosd_pixel_t fifo_data;
  logic fifo_valid;
  logic fifo_full_n;
  sosd_fifo #(.WIDTH(NB), .DEPTH(FIFO_DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_data(pixel_in_data),
    .in_valid(pixel_in_valid),
    .in_ready(fifo_full_n),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(pix_fall)
  );

  // Bus decode
  wire ap_take = hsel & htrans[1] & hready;
  wire [7:0] rd_addr = haddr[7:0];
  wire ana_det = (ana_timer_reg != 16'h0000);
  wire dig_det = (dig_timer_reg != 16'h0000);
  wire [31:0] status_word = {27'h0, ~fifo_valid, ~fifo_full_n, dig_det, ana_det, act_reg};
  wire [31:0] rd_mux =
    (rd_addr == `SOSD_CTRL_ADDR) ? {{(32-`SOSD_CTRL_W){1'b0}}, ctrl_reg} :
    (rd_addr == `SOSD_HSPOS_ADDR) ? {hs_wid_reg, hs_pos_reg} :
    (rd_addr == `SOSD_STATUS_ADDR) ? status_word :
    (rd_addr == `SOSD_SCANLO_ADDR) ? scan_reg[31:0] :
    (rd_addr == `SOSD_SCANHI_ADDR) ? {16'h0000, scan_reg[NB-1:32]} : 32'h0000_0000;
  wire wr_en = ap_valid_reg & ap_write_reg;
  wire wr_ctrl = wr_en & (ap_addr_reg == `SOSD_CTRL_ADDR);
  wire wr_hspos = wr_en & (ap_addr_reg == `SOSD_HSPOS_ADDR);

  // Sync level source and next activity
  wire hs_rebuilt = (hs_state_reg == HS_PULSE);
  wire hs_level = dig_mode ? dhs_s : hs_rebuilt;
  wire act_next = (ana_det | dig_det) & ~pdown;

  // Address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end else begin
      hreadyout_reg <= 1'b1;
      if (hready) begin
        ap_valid_reg <= ap_take;
        ap_write_reg <= hwrite;
        ap_addr_reg <= haddr[7:0];
      end
      if (ap_take && !hwrite) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `SOSD_CTRL_RST;
      hs_pos_reg <= 16'(`SOSD_HSPOS_RST >> `SOSD_HSPOS_POS_LSB);
      hs_wid_reg <= 16'(`SOSD_HSPOS_RST >> `SOSD_HSPOS_WID_LSB);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[`SOSD_CTRL_W-1:0];
      end
      if (wr_hspos) begin
        hs_pos_reg <= hwdata[`SOSD_HSPOS_POS_LSB +: 16];
        hs_wid_reg <= hwdata[`SOSD_HSPOS_WID_LSB +: 16];
      end
    end
  end

  // Pin edge history and activity timers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_reg <= 7'h00;
      ana_timer_reg <= 16'h0000;
      dig_timer_reg <= 16'h0000;
      act_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_sync;
      ana_timer_reg <= ahs_rise ? 16'(ACT_TIMEOUT_CYC) : (ana_det ? ana_timer_reg - 16'h0001 : 16'h0000);
      dig_timer_reg <= de_rise ? 16'(ACT_TIMEOUT_CYC) : (dig_det ? dig_timer_reg - 16'h0001 : 16'h0000);
      act_reg <= act_next;
    end
  end

  // Output clock pair, true and complement
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 8'h00;
      pclk_reg <= 1'b0;
      pclk_n_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
      if (div_tick) begin
        pclk_reg <= ~pclk_reg;
        pclk_n_reg <= pclk_reg;
      end
    end
  end

  // Analog sync rebuild: delay then pulse, counted in pixel periods
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_state_reg <= HS_IDLE;
      hs_cnt_reg <= 16'h0000;
    end else if (ahs_rise) begin
      hs_state_reg <= HS_WAIT;
      hs_cnt_reg <= 16'h0000;
    end else if (pix_fall) begin
      case (hs_state_reg)
        HS_WAIT: begin
          if (hs_cnt_reg >= hs_pos_reg) begin
            hs_state_reg <= HS_PULSE;
            hs_cnt_reg <= 16'h0000;
          end else begin
            hs_cnt_reg <= hs_cnt_reg + 16'h0001;
          end
        end
        HS_PULSE: begin
          if (hs_cnt_reg + 16'h0001 >= hs_wid_reg) begin
            hs_state_reg <= HS_IDLE;
          end
          hs_cnt_reg <= hs_cnt_reg + 16'h0001;
        end
        default: begin
          hs_state_reg <= HS_IDLE;
        end
      endcase
    end
  end

  // Sync outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_out_reg <= 1'b0;
      vs_out_reg <= 1'b0;
    end else begin
      if (pix_fall) begin
        hs_out_reg <= hs_level ^ hs_pol;
      end
      vs_out_reg <= (vs_sep ? cvs_s : vs_s) ^ vs_pol;
    end
  end

  // Pixel data and output enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pix_reg <= '0;
      oe_n_reg <= 1'b1;
    end else begin
      if (scan_drv) begin
        pix_reg <= scan_reg;
      end else if (pix_fall && fifo_valid) begin
        pix_reg <= fifo_data;
      end
      oe_n_reg <= ~(act_next | scan_drv);
    end
  end

  // Scan register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_reg <= '0;
      sout_reg <= 1'b0;
    end else begin
      if (sclk_rise) begin
        scan_reg <= {scan_reg[NB-2:0], sin_s};
      end
      sout_reg <= scan_reg[NB-1];
    end
  end

  // Outputs
  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;
  assign pixel_in_ready = fifo_full_n;
  assign horizontal_sync_output = hs_out_reg;
  assign vertical_sync_output = vs_out_reg;
  assign pixel_out_red_a = pix_reg[`SOSD_RED_A_LSB +: 8];
  assign pixel_out_green_a = pix_reg[`SOSD_GREEN_A_LSB +: 8];
  assign pixel_out_blue_a = pix_reg[`SOSD_BLUE_A_LSB +: 8];
  assign pixel_out_red_b = pix_reg[`SOSD_RED_B_LSB +: 8];
  assign pixel_out_green_b = pix_reg[`SOSD_GREEN_B_LSB +: 8];
  assign pixel_out_blue_b = pix_reg[`SOSD_BLUE_B_LSB +: 8];
  assign pixel_out_oe_n = oe_n_reg;
  assign pixel_output_clock = pclk_reg;
  assign pixel_output_clock_n = pclk_n_reg;
  assign activity_detect = act_reg;
  assign test_shift_out = sout_reg;
endmodule : sosd_top

// *** test/sosd_partner.sv ***
// Purpose: Downstream controller latching pixel pairs.
// Assumes: Latches on the rising output clock.
// Notes: Released outputs are ignored.
`timescale 1ns/1ns
module sosd_partner (
  input wire logic pixel_output_clock,
  input wire logic pixel_out_oe_n,
  input wire logic [7:0] pixel_out_red_a,
  input wire logic [7:0] pixel_out_green_a,
  input wire logic [7:0] pixel_out_blue_a,
  input wire logic [7:0] pixel_out_red_b,
  input wire logic [7:0] pixel_out_green_b,
  input wire logic [7:0] pixel_out_blue_b,
  output logic [47:0] word,
  output logic seen
);
  wire logic [47:0] bus = {pixel_out_red_a, pixel_out_green_a, pixel_out_blue_a,
    pixel_out_red_b, pixel_out_green_b, pixel_out_blue_b};
  initial begin
    word = 48'h0;
    seen = 1'b0;
  end
  // Take a new pair only while the outputs are driven
  always @(posedge pixel_output_clock) begin
    if (!pixel_out_oe_n && bus !== word) begin
      word <= bus;
      seen <= ~seen;
    end
  end
endmodule : sosd_partner

// *** test/sosd_top_props.sv ***
// Purpose: Timing relations of the shared output stage seen at its ports.
// Assumes: One clock domain, hclk, reset hresetn.
// Notes: Bound into sosd_top below.
`timescale 1ns/1ns
module sosd_top_props #(
  parameter int ACT_TIMEOUT_CYC = 1000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hwrite,
  input wire logic vsync_in,
  input wire logic composite_vsync_in,
  input wire logic analog_hsync_in,
  input wire logic display_enable_input,
  input wire logic test_shift_clock,
  input wire logic test_shift_out,
  input wire logic horizontal_sync_output,
  input wire logic vertical_sync_output,
  input wire logic pixel_out_oe_n,
  input wire logic pixel_output_clock,
  input wire logic pixel_output_clock_n,
  input wire logic activity_detect
);
  logic sc_q, a_q, d_q, v_q, c_q;
  logic [7:0] sc_cnt, vs_cnt;
  logic [15:0] ac_cnt;
  // Events that restart the counters
  wire logic sc_rise = test_shift_clock && !sc_q;
  wire logic src_edge = (analog_hsync_in && !a_q) || (display_enable_input && !d_q);
  wire logic vs_evt = (vsync_in != v_q) || (composite_vsync_in != c_q) || (hsel && htrans[1] && hready && hwrite);
  // Cycles since the last scan clock rise, source edge and vsync cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {sc_q, a_q, d_q, v_q, c_q} <= 5'h00;
      sc_cnt <= 8'hFF;
      vs_cnt <= 8'hFF;
      ac_cnt <= 16'hFFFF;
    end else begin
      {sc_q, a_q, d_q, v_q, c_q} <= {test_shift_clock, analog_hsync_in, display_enable_input, vsync_in, composite_vsync_in};
      sc_cnt <= sc_rise ? 8'h00 : sc_cnt + {7'h00, sc_cnt != 8'hFF};
      vs_cnt <= vs_evt ? 8'h00 : vs_cnt + {7'h00, vs_cnt != 8'hFF};
      ac_cnt <= src_edge ? 16'h0000 : ac_cnt + {15'h0000, ac_cnt != 16'hFFFF};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_clk_pair; pixel_output_clock_n == !pixel_output_clock; endproperty
  property p_hs_edge; $changed(horizontal_sync_output) |-> $fell(pixel_output_clock); endproperty
  property p_vs_cause; $changed(vertical_sync_output) |-> vs_cnt <= 8'd6; endproperty
  property p_oe_on; activity_detect |-> !pixel_out_oe_n; endproperty
  property p_act_rise; $rose(activity_detect) |-> ac_cnt <= ACT_TIMEOUT_CYC; endproperty
  property p_act_hold; activity_detect |-> ac_cnt <= ACT_TIMEOUT_CYC + 8; endproperty
  property p_scan_dly; $changed(test_shift_out) |-> sc_cnt <= 8'd6; endproperty
  property p_scan_once; $changed(test_shift_out) |=> $stable(test_shift_out) [*3]; endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("clock pair not complementary");
  a_hs_edge: assert property (p_hs_edge) else $error("hsync moved off a falling clock");
  a_vs_cause: assert property (p_vs_cause) else $error("vsync moved without cause");
  a_oe_on: assert property (p_oe_on) else $error("pixels released while active");
  a_act_rise: assert property (p_act_rise) else $error("activity without source edge");
  a_act_hold: assert property (p_act_hold) else $error("activity held past timeout");
  a_scan_dly: assert property (p_scan_dly) else $error("scan out moved without scan clock");
  a_scan_once: assert property (p_scan_once) else $error("scan out moved twice");
  c_act: cover property ($rose(activity_detect));
  c_scan: cover property ($changed(test_shift_out));
  c_hs: cover property ($changed(horizontal_sync_output));
endmodule : sosd_top_props

bind sosd_top sosd_top_props #(.ACT_TIMEOUT_CYC(ACT_TIMEOUT_CYC)) u_props (
  .hclk, .hresetn, .hsel, .htrans, .hready, .hwrite, .vsync_in, .composite_vsync_in,
  .analog_hsync_in, .display_enable_input, .test_shift_clock, .test_shift_out,
  .horizontal_sync_output, .vertical_sync_output, .pixel_out_oe_n,
  .pixel_output_clock, .pixel_output_clock_n, .activity_detect
);

// *** test/tb_sosd_top.sv ***
// Purpose: Self-checking bench of the shared output stage.
// Assumes: Activity timeout shortened to 50 cycles.
// Notes: Reads and pixel pairs are checked from queues.
`timescale 1ns/1ns
`include "sosd_regs.svh"
module tb_sosd_top;
  import sosd_pkg::*;
  localparam int ACT = 50;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pixel_in_valid = 0, rd_ph = 0, de_run = 0;
  logic analog_hsync_in = 0, vsync_in = 0, composite_vsync_in = 0, digital_hsync_in = 0;
  logic display_enable_input = 0, test_shift_clock = 0, test_shift_in = 0;
  logic [31:0] haddr = 0, hwdata = 0, seed = 32'hE721D7C5, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  sosd_pixel_t pixel_in_data = '0;
  logic hreadyout, hresp, pixel_in_ready, horizontal_sync_output, vertical_sync_output;
  logic [7:0] pixel_out_red_a, pixel_out_green_a, pixel_out_blue_a;
  logic [7:0] pixel_out_red_b, pixel_out_green_b, pixel_out_blue_b;
  logic pixel_out_oe_n, pixel_output_clock, pixel_output_clock_n, activity_detect, test_shift_out, p_seen;
  logic [47:0] p_word;
  logic [31:0] rd_q[$];
  logic [47:0] pix_q[$];
  int miscompares = 0, tests_run = 0, hs_hi = 0;
  wire logic hready = hreadyout;
  sosd_top #(.ACT_TIMEOUT_CYC(ACT)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .pixel_in_data, .pixel_in_valid, .pixel_in_ready,
    .analog_hsync_in, .vsync_in, .composite_vsync_in, .digital_hsync_in, .display_enable_input,
    .test_shift_clock, .test_shift_in, .horizontal_sync_output, .vertical_sync_output,
    .pixel_out_red_a, .pixel_out_green_a, .pixel_out_blue_a, .pixel_out_red_b, .pixel_out_green_b,
    .pixel_out_blue_b, .pixel_out_oe_n, .pixel_output_clock, .pixel_output_clock_n,
    .activity_detect, .test_shift_out);
  sosd_partner u_partner (.pixel_output_clock, .pixel_out_oe_n, .pixel_out_red_a, .pixel_out_green_a,
    .pixel_out_blue_a, .pixel_out_red_b, .pixel_out_green_b, .pixel_out_blue_b, .word(p_word), .seen(p_seen));
  always #50 hclk = ~hclk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [47:0] rnd48();
    logic [31:0] t;
    t = xs();
    return {t[15:0], xs()};
  endfunction : rnd48
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // One single AHB-Lite transfer, waiting on the slave's ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_ph <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask : ahb
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge hclk);
  endtask : cyc
  // One scan bit, scan clock period 800 ns
  task automatic shift(input logic b, output logic o);
    @(posedge hclk);
    test_shift_in <= b;
    o = test_shift_out;
    @(posedge hclk);
    test_shift_clock <= 1'b1;
    repeat (4) @(posedge hclk);
    test_shift_clock <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : shift
  // Read data check at the end of each data phase
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) chk({15'h0, hresp, hrdata}, {16'h0, rd_q.pop_front()});
  end
  // Pixel pairs seen by the partner
  always @(p_seen) begin
    if (pix_q.size() != 0) chk(p_word, pix_q.pop_front());
  end
  // Source toggler keeping the digital side active
  always @(posedge hclk) begin
    if (de_run) display_enable_input <= ~display_enable_input;
  end
  // Cycles with the sync output high, for the rebuilt pulse width
  always @(negedge hclk) begin
    if (horizontal_sync_output === 1'b1) hs_hi++;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_sim();
  end
  initial begin
    logic [31:0] v;
    logic [47:0] w, p;
    logic o, full;
    int n;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(`SOSD_CTRL_ADDR, 32'h0);
    rd(`SOSD_HSPOS_ADDR, `SOSD_HSPOS_RST);
    rd(`SOSD_STATUS_ADDR, 32'h10);
    rd(32'h40, 32'h0);
    v = xs() & 32'h2F;
    ahb(1'b1, `SOSD_CTRL_ADDR, v);
    rd(`SOSD_CTRL_ADDR, v);
    $display("test registers done");
    digital_hsync_in <= 1'b1;
    vsync_in <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, `SOSD_CTRL_ADDR, 32'h8 | i);
      cyc(20);
      chk({horizontal_sync_output, vertical_sync_output}, {~i[0], ~(i[1] ^ i[2])});
    end
    $display("test sync done");
    ahb(1'b1, `SOSD_HSPOS_ADDR, 32'h0003_0002);
    ahb(1'b1, `SOSD_CTRL_ADDR, 32'h0);
    n = hs_hi;
    for (int s = 0; s < 2; s++) begin
      @(posedge hclk);
      if (s == 0) analog_hsync_in <= 1'b1;
      else display_enable_input <= 1'b1;
      cyc(4);
      @(posedge hclk);
      analog_hsync_in <= 1'b0;
      display_enable_input <= 1'b0;
      cyc(10);
      chk({activity_detect, pixel_out_oe_n}, 2'b10);
      cyc(ACT + 20);
      chk({activity_detect, pixel_out_oe_n}, 2'b01);
    end
    chk(48'(hs_hi - n), 48'(6 * `SOSD_PIX_DIV));
    de_run <= 1'b1;
    ahb(1'b1, `SOSD_CTRL_ADDR, 32'h10);
    cyc(10);
    chk({activity_detect, pixel_out_oe_n}, 2'b01);
    ahb(1'b1, `SOSD_CTRL_ADDR, 32'h0);
    cyc(10);
    chk({activity_detect, pixel_out_oe_n}, 2'b10);
    $display("test activity done");
    w = rnd48();
    @(posedge hclk);
    pixel_in_data <= w;
    pixel_in_valid <= 1'b1;
    n = 0;
    full = 0;
    while (n < 12) begin
      @(negedge hclk);
      if (pixel_in_ready === 1'b1) begin
        pix_q.push_back(w);
        n++;
        w = rnd48();
        @(posedge hclk);
        pixel_in_data <= w;
      end else full = 1;
    end
    pixel_in_valid <= 1'b0;
    chk(full, 1'b1);
    cyc(80);
    chk(48'(pix_q.size()), 48'h0);
    de_run <= 1'b0;
    $display("test pixel stream done");
    ahb(1'b1, `SOSD_CTRL_ADDR, 32'h20);
    p = rnd48();
    for (int i = 47; i >= 0; i--) shift(p[i], o);
    cyc(2);
    chk({pixel_out_red_a, pixel_out_green_a, pixel_out_blue_a, pixel_out_red_b,
      pixel_out_green_b, pixel_out_blue_b}, p);
    chk(pixel_out_oe_n, 1'b0);
    rd(`SOSD_SCANLO_ADDR, p[31:0]);
    rd(`SOSD_SCANHI_ADDR, {16'h0, p[47:32]});
    for (int i = 47; i >= 0; i--) begin
      shift(~p[i], o);
      chk(o, p[i]);
    end
    $display("test scan done");
    end_sim();
  end
endmodule : tb_sosd_top
